/* design/gpc_map.vh */
// gpc_map.vh: offsets, field positions, reset values and timing counts of the pin controller
// assumes: included by gpc_port.v only, 32-bit APB data, byte addressed
`ifndef GPC_MAP_VH
`define GPC_MAP_VH

// data register group: bit 4 picks the register, bits 3:2 pick the operation
`define GPC_OFS_DIR 8'h00
`define GPC_OFS_DIRCLR 8'h04
`define GPC_OFS_DIRSET 8'h08
`define GPC_OFS_DIRTGL 8'h0C
`define GPC_OFS_OUT 8'h10
`define GPC_OFS_OUTCLR 8'h14
`define GPC_OFS_OUTSET 8'h18
`define GPC_OFS_OUTTGL 8'h1C
`define GPC_OFS_IN 8'h20
// configuration registers, blocked in standby
`define GPC_OFS_CTRL 8'h24
`define GPC_OFS_PMUXEN 8'h28
`define GPC_OFS_INEN 8'h2C
`define GPC_OFS_PULLEN 8'h30
`define GPC_OFS_ANALOG 8'h34
`define GPC_OFS_DBG 8'h38

// operation codes, also used by the event router port
`define GPC_OP_WR 2'h0
`define GPC_OP_CLR 2'h1
`define GPC_OP_SET 2'h2
`define GPC_OP_TGL 2'h3

// field positions
`define GPC_BIT_TARGET 4
`define GPC_CTRL_SAMPLING_W 4
`define GPC_DBG_HALT_BIT 0

// reset values
`define GPC_RST_WORD 32'h0000_0000
`define GPC_RST_CTRL 4'h0

// timing: the on-demand synchroniser costs two controller clock cycles
`define GPC_SYNC_CYC 2'h2
// one cycle to register the read data
`define GPC_RD_CYC 2'h1

`endif

/* design/gpc_port.v */
// gpc_port.v: one 32-pin group of the general-purpose I/O pin controller
// assumes: CLK is the processor main clock; APB_CLKEN marks the edges of the divided bus clock;
// pads, peripheral and event router lines are provided by the surrounding chip
`include "gpc_map.vh"

module gpc_port (
  input wire CLK,
  input wire SRST,
  input wire CE,
  input wire APB_CLKEN,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  input wire [3:0] PSTRB,
  output wire [31:0] PRDATA,
  output wire PREADY,
  output wire PSLVERR,
  input wire LB_SEL,
  input wire LB_WRITE,
  input wire [7:0] LB_ADDR,
  input wire [31:0] LB_WDATA,
  input wire [3:0] LB_BE,
  output wire [31:0] LB_RDATA,
  input wire EV_VALID,
  input wire [1:0] EV_OP,
  input wire [31:0] EV_MASK,
  output wire EV_READY,
  input wire DEBUG_HALT,
  input wire EXT_DEBUG,
  input wire WPROT_EN,
  input wire STANDBY,
  input wire SHUTDOWN,
  input wire [31:0] PAD_IN,
  output wire [31:0] PAD_OUT,
  output wire [31:0] PAD_OE_N,
  output wire [31:0] PAD_INEN,
  output wire [31:0] PAD_PULLEN,
  output wire [31:0] PAD_PULLUP,
  input wire [31:0] PERIPH_OUT,
  input wire [31:0] PERIPH_OE,
  output wire [31:0] PERIPH_IN
);

////////////////////////////////////////////////////////////////////////////////
// state

reg [31:0] dir_q;
reg [31:0] out_q;
reg [3:0] ctrl_q;
reg [31:0] pmuxen_q;
reg [31:0] inen_q;
reg [31:0] pullen_q;
reg [31:0] analog_q;
reg dbg_q;
reg [31:0] sync1_q;
reg [31:0] sync2_q;
reg [31:0] pad_out_q;
reg [31:0] pad_oe_n_q;
reg [31:0] pad_inen_q;
reg [31:0] pad_pullen_q;
reg [31:0] pad_pullup_q;
reg [31:0] prdata_q;
reg [31:0] lb_rdata_q;
reg [1:0] wait_q;

// byte lanes to bit mask
function [31:0] lane_mask;
  input [3:0] be;
  begin
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  end
endfunction

// one atomic update of a data register; unselected lanes keep their bits
function [31:0] apply_op;
  input [31:0] cur;
  input [1:0] op;
  input [31:0] d;
  input [31:0] m;
  begin
    case (op)
      `GPC_OP_WR: apply_op = (cur & ~m) | (d & m);
      `GPC_OP_CLR: apply_op = cur & ~(d & m);
      `GPC_OP_SET: apply_op = cur | (d & m);
      `GPC_OP_TGL: apply_op = cur ^ (d & m);
      default: apply_op = cur;
    endcase
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// access arbitration

wire halted = DEBUG_HALT & dbg_q;
wire lb_data = (LB_ADDR[7:5] == 3'h0);
wire lb_wr = LB_SEL & LB_WRITE & lb_data;
wire ev_go = EV_VALID & ~LB_SEL & ~halted;
assign EV_READY = ~LB_SEL & ~halted;
wire apb_access = PSEL & PENABLE;
// bridge stalls on any concurrent access
wire apb_clash = LB_SEL | EV_VALID;
wire apb_is_data = (PADDR[7:5] == 3'h0);
wire apb_is_in = (PADDR == `GPC_OFS_IN);
wire apb_is_cfg = (PADDR == `GPC_OFS_CTRL) | (PADDR == `GPC_OFS_PMUXEN) | (PADDR == `GPC_OFS_INEN) |
                  (PADDR == `GPC_OFS_PULLEN) | (PADDR == `GPC_OFS_ANALOG) | (PADDR == `GPC_OFS_DBG);
wire apb_mapped = apb_is_data | apb_is_in | apb_is_cfg;
wire all_sampling = &ctrl_q;
// input reads take two extra cycles unless all four CTRL sampling bits are set
wire [1:0] need = (apb_is_in & ~PWRITE & ~all_sampling) ? (`GPC_RD_CYC + `GPC_SYNC_CYC) : `GPC_RD_CYC;
// protection lifted for debug halt and debugger
wire wprot = WPROT_EN & ~DEBUG_HALT & ~EXT_DEBUG;
wire apb_err = ~apb_mapped | (apb_is_cfg & STANDBY) | (PWRITE & (apb_is_in | wprot));
// bridge answers only on bus clock edges
// a frozen clock enable must not complete a transfer it cannot apply
assign PREADY = apb_access & APB_CLKEN & CE & ~apb_clash & (wait_q >= need);
assign PSLVERR = PREADY & apb_err;
wire apb_wr = PREADY & PWRITE & ~apb_err;
wire ondemand = apb_access & apb_is_in & ~PWRITE;
assign PRDATA = prdata_q;
assign LB_RDATA = lb_rdata_q;

////////////////////////////////////////////////////////////////////////////////
// read data

wire [31:0] in_val = sync2_q & inen_q;
reg [31:0] apb_rd;
reg [31:0] lb_rd;

always @* begin
  apb_rd = `GPC_RST_WORD;
  if (!(apb_is_cfg & STANDBY)) begin
    case (PADDR)
      `GPC_OFS_DIR, `GPC_OFS_DIRCLR, `GPC_OFS_DIRSET, `GPC_OFS_DIRTGL: apb_rd = dir_q;
      `GPC_OFS_OUT, `GPC_OFS_OUTCLR, `GPC_OFS_OUTSET, `GPC_OFS_OUTTGL: apb_rd = out_q;
      `GPC_OFS_IN: apb_rd = in_val;
      `GPC_OFS_CTRL: apb_rd = {28'h000_0000, ctrl_q};
      `GPC_OFS_PMUXEN: apb_rd = pmuxen_q;
      `GPC_OFS_INEN: apb_rd = inen_q;
      `GPC_OFS_PULLEN: apb_rd = pullen_q;
      `GPC_OFS_ANALOG: apb_rd = analog_q;
      `GPC_OFS_DBG: apb_rd = {31'h0000_0000, dbg_q};
      default: apb_rd = `GPC_RST_WORD;
    endcase
  end
end

// local bus sees dir, out and the read-only input
always @* begin
  case (LB_ADDR)
    `GPC_OFS_DIR, `GPC_OFS_DIRCLR, `GPC_OFS_DIRSET, `GPC_OFS_DIRTGL: lb_rd = dir_q;
    `GPC_OFS_OUT, `GPC_OFS_OUTCLR, `GPC_OFS_OUTSET, `GPC_OFS_OUTTGL: lb_rd = out_q;
    `GPC_OFS_IN: lb_rd = in_val;
    default: lb_rd = `GPC_RST_WORD;
  endcase
end

////////////////////////////////////////////////////////////////////////////////
// registers

wire [31:0] lb_m = lane_mask(LB_BE);
wire [31:0] apb_m = lane_mask(PSTRB);

////////////////////////////////////////////////////////////////////////////////
// next state

reg [31:0] dir_d;
reg [31:0] out_d;
reg [3:0] ctrl_d;
reg [31:0] pmuxen_d;
reg [31:0] inen_d;
reg [31:0] pullen_d;
reg [31:0] analog_d;
reg dbg_d;
reg [31:0] prdata_d;
reg [31:0] lb_rdata_d;
reg [1:0] wait_d;

// wait counter saturates so a long wait for a bus clock edge cannot wrap it; a clash holds it
always @* begin
  wait_d = wait_q;
  if (!apb_access | PREADY) begin
    wait_d = 2'h0;
  end else if (~apb_clash & (wait_q != 2'h3)) begin
    wait_d = wait_q + 2'h1;
  end
end

always @* begin
  dir_d = dir_q;
  out_d = out_q;
  ctrl_d = ctrl_q;
  pmuxen_d = pmuxen_q;
  inen_d = inen_q;
  pullen_d = pullen_q;
  analog_d = analog_q;
  dbg_d = dbg_q;
  prdata_d = prdata_q;
  lb_rdata_d = lb_rdata_q;
  // answer on the next edge, never a wait
  if (LB_SEL & ~LB_WRITE) begin
    lb_rdata_d = lb_rd;
  end
  // read data stands before ready, so the master takes it at the ready edge
  if (apb_access & ~PREADY) begin
    prdata_d = apb_rd;
  end
  // local write now, bridge stays stalled
  if (lb_wr) begin
    if (LB_ADDR[`GPC_BIT_TARGET]) begin
      out_d = apply_op(out_q, LB_ADDR[3:2], LB_WDATA, lb_m);
    end else begin
      dir_d = apply_op(dir_q, LB_ADDR[3:2], LB_WDATA, lb_m);
    end
  end else if (ev_go) begin
    // event actions act on output values
    out_d = apply_op(out_q, EV_OP, EV_MASK, 32'hFFFF_FFFF);
  end else if (apb_wr) begin
    // same data registers through the bridge
    if (apb_is_data & PADDR[`GPC_BIT_TARGET]) begin
      out_d = apply_op(out_q, PADDR[3:2], PWDATA, apb_m);
    end else if (apb_is_data) begin
      dir_d = apply_op(dir_q, PADDR[3:2], PWDATA, apb_m);
    end
    case (PADDR)
      `GPC_OFS_CTRL: begin
        if (PSTRB[0]) begin
          ctrl_d = PWDATA[3:0];
        end
      end
      `GPC_OFS_PMUXEN: pmuxen_d = (pmuxen_q & ~apb_m) | (PWDATA & apb_m);
      `GPC_OFS_INEN: inen_d = (inen_q & ~apb_m) | (PWDATA & apb_m);
      `GPC_OFS_PULLEN: pullen_d = (pullen_q & ~apb_m) | (PWDATA & apb_m);
      `GPC_OFS_ANALOG: analog_d = (analog_q & ~apb_m) | (PWDATA & apb_m);
      `GPC_OFS_DBG: begin
        if (PSTRB[0]) begin
          dbg_d = PWDATA[`GPC_DBG_HALT_BIT];
        end
      end
      default: dbg_d = dbg_q;
    endcase
  end
end

////////////////////////////////////////////////////////////////////////////////
// register update

always @(posedge CLK) begin
  if (SRST | SHUTDOWN) begin
    dir_q <= `GPC_RST_WORD;
    out_q <= `GPC_RST_WORD;
    ctrl_q <= `GPC_RST_CTRL;
    pmuxen_q <= `GPC_RST_WORD;
    inen_q <= `GPC_RST_WORD;
    pullen_q <= `GPC_RST_WORD;
    analog_q <= `GPC_RST_WORD;
    dbg_q <= 1'b0;
    prdata_q <= `GPC_RST_WORD;
    lb_rdata_q <= `GPC_RST_WORD;
    wait_q <= 2'h0;
  end else if (CE) begin
    dir_q <= dir_d;
    out_q <= out_d;
    ctrl_q <= ctrl_d;
    pmuxen_q <= pmuxen_d;
    inen_q <= inen_d;
    pullen_q <= pullen_d;
    analog_q <= analog_d;
    dbg_q <= dbg_d;
    prdata_q <= prdata_d;
    lb_rdata_q <= lb_rdata_d;
    wait_q <= wait_d;
  end
end

////////////////////////////////////////////////////////////////////////////////
// per-pin synchroniser and pad latch

assign PAD_OUT = pad_out_q;
assign PAD_OE_N = pad_oe_n_q;
assign PAD_INEN = pad_inen_q;
assign PAD_PULLEN = pad_pullen_q;
assign PAD_PULLUP = pad_pullup_q;
// peripheral reads the synchronised pad level
assign PERIPH_IN = sync2_q & pmuxen_q;

genvar i;
generate
  for (i = 0; i < 32; i = i + 1) begin : g_pin
    // clocking only on demand saves power; continuous groups cost more
    wire samp = ctrl_q[i / 8] | ondemand | pmuxen_q[i];
    wire dig = ~analog_q[i];
    wire pmux = pmuxen_q[i] & dig;
    wire drive = pmux ? PERIPH_OE[i] : dir_q[i];
    // analog pin: no driver, input or pull
    wire nxt_oe_n = ~(dig & drive);
    wire nxt_out = pmux ? PERIPH_OUT[i] : out_q[i];
    wire nxt_inen = dig & (pmux | inen_q[i]);
    // pull only undriven, direction from output bit
    wire nxt_pull = dig & ~pmux & ~dir_q[i] & pullen_q[i];

    always @(posedge CLK) begin
      if (SRST | SHUTDOWN) begin
        sync1_q[i] <= 1'b0;
        sync2_q[i] <= 1'b0;
      end else if (CE & ~halted & samp) begin
        sync1_q[i] <= PAD_IN[i];
        sync2_q[i] <= sync1_q[i];
      end
    end

    always @(posedge CLK) begin
      // reset: input, driver, buffer, pull off
      if (SRST) begin
        pad_oe_n_q[i] <= 1'b1;
        pad_out_q[i] <= 1'b0;
        pad_inen_q[i] <= 1'b0;
        pad_pullen_q[i] <= 1'b0;
        pad_pullup_q[i] <= 1'b0;
      end else if (CE & ~SHUTDOWN) begin
        pad_oe_n_q[i] <= nxt_oe_n;
        pad_out_q[i] <= nxt_out;
        pad_inen_q[i] <= nxt_inen;
        pad_pullen_q[i] <= nxt_pull;
        pad_pullup_q[i] <= out_q[i];
      end
    end
  end
endgenerate

endmodule // gpc_port

/* verif/gpc_port_sva.sv */
// gpc_port_sva.sv: port assertions for one pin group
// assumes: bound to gpc_port, single clock domain
module gpc_port_sva (
  input wire CLK,
  input wire SRST,
  input wire PSEL,
  input wire PENABLE,
  input wire PREADY,
  input wire APB_CLKEN,
  input wire LB_SEL,
  input wire EV_VALID,
  input wire EV_READY,
  input wire DEBUG_HALT,
  input wire SHUTDOWN,
  input wire [31:0] PAD_OUT,
  input wire [31:0] PAD_OE_N,
  input wire [31:0] PAD_PULLEN,
  input wire [31:0] PAD_PULLUP
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  ////////////////////////////////
  sequence s_first;
    PSEL && PENABLE && !$past(PENABLE);
  endsequence
  sequence s_clash;
    PSEL && PENABLE && (LB_SEL || EV_VALID);
  endsequence
  property p_rst;
    disable iff (1'b0) SRST [*3] |-> PAD_OE_N == 32'hFFFF_FFFF && PAD_PULLEN == 32'h0000_0000;
  endproperty
  property p_first;
    s_first |-> !PREADY;
  endproperty
  property p_clash;
    s_clash |-> !PREADY;
  endproperty
  property p_clken;
    PREADY |-> APB_CLKEN && PSEL && PENABLE;
  endproperty
  property p_lbpri;
    LB_SEL |-> !EV_READY;
  endproperty
  property p_evgo;
    !LB_SEL && !DEBUG_HALT |-> EV_READY;
  endproperty
  property p_pull;
    (PAD_PULLEN & (PAD_PULLUP ^ PAD_OUT)) == 32'h0000_0000;
  endproperty
  property p_drv;
    (PAD_PULLEN & ~PAD_OE_N) == 32'h0000_0000;
  endproperty
  property p_hold;
    SHUTDOWN ##1 SHUTDOWN |-> $stable(PAD_OUT) && $stable(PAD_PULLEN);
  endproperty
  a_rst: assert property (p_rst) else $error("pads not idle in reset");
  a_first: assert property (p_first) else $error("ready in first access cycle");
  a_clash: assert property (p_clash) else $error("bridge served during clash");
  a_clken: assert property (p_clken) else $error("ready off bus clock edge");
  a_lbpri: assert property (p_lbpri) else $error("event beat local bus");
  a_evgo: assert property (p_evgo) else $error("event stalled needlessly");
  a_pull: assert property (p_pull) else $error("pull direction off");
  a_drv: assert property (p_drv) else $error("pull on driven pin");
  a_hold: assert property (p_hold) else $error("pad latch moved");
endmodule // gpc_port_sva

/* verif/gpc_cpu_model.sv */
// gpc_cpu_model.sv: processor end of the local bus
// assumes: one access per call, launched after a rising edge
module gpc_cpu_model (
  input wire CLK,
  output logic LB_SEL,
  output logic LB_WRITE,
  output logic [7:0] LB_ADDR,
  output logic [31:0] LB_WDATA,
  output logic [3:0] LB_BE
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {LB_SEL, LB_WRITE, LB_ADDR, LB_WDATA, LB_BE} = '0;
  end
  task automatic go(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge CLK);
    LB_SEL <= 1'b1;
    LB_WRITE <= w;
    LB_ADDR <= a;
    LB_WDATA <= d;
    LB_BE <= be;
    @(posedge CLK);
    LB_SEL <= 1'b0;
    // idle address and data lines carry junk, not the last value
    LB_ADDR <= ~a;
    LB_WDATA <= ~d;
  endtask
endmodule // gpc_cpu_model

/* verif/gpc_port_test.sv */
// gpc_port_test.sv: register level test of one pin group
// assumes: gpc_port, local bus from gpc_cpu_model
module gpc_port_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK, SRST, CE, APB_CLKEN, PSEL, PENABLE, PWRITE, EV_VALID, DEBUG_HALT, EXT_DEBUG, WPROT_EN, STANDBY, SHUTDOWN;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, EV_MASK, PAD_IN, PERIPH_OUT, PERIPH_OE;
  logic [3:0] PSTRB, stb;
  logic [1:0] EV_OP;
  wire [31:0] PRDATA, LB_RDATA, LB_WDATA, PAD_OUT, PAD_OE_N, PAD_INEN, PAD_PULLEN, PAD_PULLUP, PERIPH_IN;
  wire PREADY, PSLVERR, LB_SEL, LB_WRITE, EV_READY;
  wire [7:0] LB_ADDR;
  wire [3:0] LB_BE;
  int fails = 0, samples_checked = 0, cyc = 0;
  gpc_port u_dut (.CLK, .SRST, .CE, .APB_CLKEN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSTRB, .PRDATA,
    .PREADY, .PSLVERR, .LB_SEL, .LB_WRITE, .LB_ADDR, .LB_WDATA, .LB_BE, .LB_RDATA, .EV_VALID, .EV_OP,
    .EV_MASK, .EV_READY, .DEBUG_HALT, .EXT_DEBUG, .WPROT_EN, .STANDBY, .SHUTDOWN, .PAD_IN, .PAD_OUT,
    .PAD_OE_N, .PAD_INEN, .PAD_PULLEN, .PAD_PULLUP, .PERIPH_OUT, .PERIPH_OE, .PERIPH_IN);
  gpc_cpu_model u_cpu (.CLK, .LB_SEL, .LB_WRITE, .LB_ADDR, .LB_WDATA, .LB_BE);
  ////////////////////////////////
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  // bus clock at half rate
  always @(posedge CLK) APB_CLKEN <= ~APB_CLKEN;
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      wrap_up;
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("wrong value at %0t: %h vs %h", $time, s, e);
    end
  endtask
  task automatic wrap_up;
    if (fails == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e, input logic r);
    @(posedge CLK);
    {PSEL, PWRITE, PADDR, PWDATA, PSTRB} <= {1'b1, w, a, d, stb};
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(negedge CLK);
    while (PREADY !== 1'b1) @(negedge CLK);
    chk(32'(PSLVERR), 32'(r));
    if (!w) chk(PRDATA, e);
    @(posedge CLK);
    {PSEL, PENABLE, PWDATA} <= {2'b00, ~d};
  endtask
  task automatic ev(input logic [1:0] op, input logic [31:0] m);
    @(posedge CLK);
    {EV_VALID, EV_OP, EV_MASK} <= {1'b1, op, m};
    @(negedge CLK);
    while (EV_READY !== 1'b1) @(negedge CLK);
    @(posedge CLK);
    {EV_VALID, EV_MASK} <= {1'b0, ~m};
  endtask
  task automatic lbr(input logic [7:0] a, input logic [31:0] e);
    u_cpu.go(1'b0, a, 32'h0000_0000, 4'hF);
    @(negedge CLK);
    chk(LB_RDATA, e);
  endtask
  ////////////////////////////////
  initial begin
    {APB_CLKEN, PSEL, PENABLE, PWRITE, EV_VALID, DEBUG_HALT, EXT_DEBUG, WPROT_EN, STANDBY, SHUTDOWN} = '0;
    {PADDR, PWDATA, EV_MASK, EV_OP} = '0;
    {SRST, CE, stb, PSTRB} = {2'b11, 8'hFF};
    {PAD_IN, PERIPH_OUT, PERIPH_OE} = {32'hA5A5_0F0F, 32'h0000_0004, 32'h0000_0004};
    repeat (16) @(posedge CLK);
    SRST <= 1'b0;
    @(negedge CLK);
    chk(PAD_OE_N, 32'hFFFF_FFFF);
    apb(1, 8'h00, 32'h0000_00F0, 0, 0);
    stb = 4'h1;
    apb(1, 8'h0C, 32'hFFFF_FF11, 0, 0);
    stb = 4'hF;
    apb(1, 8'h04, 32'h0000_00C0, 0, 0);
    apb(0, 8'h00, 0, 32'h0000_0021, 0);
    chk(PAD_OE_N, 32'hFFFF_FFDE);
    u_cpu.go(1, 8'h18, 32'h0000_0111, 4'hF);
    u_cpu.go(1, 8'h1C, 32'h0000_0303, 4'h2);
    ev(2'h1, 32'h0000_0001);
    fork
      apb(0, 8'h10, 0, 32'h0000_0270, 0);
      ev(2'h2, 32'h0000_0020);
      u_cpu.go(1, 8'h18, 32'h0000_0040, 4'hF);
    join
    u_cpu.go(1, 8'h18, 32'h0000_0002, 4'hF);
    lbr(8'h10, 32'h0000_0272);
    apb(1, 8'h30, 32'h0000_000B, 0, 0);
    repeat (2) @(negedge CLK);
    chk(PAD_PULLEN & PAD_PULLUP, 32'h0000_0002);
    apb(1, 8'h20, 32'h0000_0001, 0, 1);
    apb(0, 8'h3C, 0, 0, 1);
    @(posedge CLK) WPROT_EN <= 1'b1;
    apb(1, 8'h08, 32'h0000_0002, 0, 1);
    @(posedge CLK) DEBUG_HALT <= 1'b1;
    apb(1, 8'h08, 32'h0000_0002, 0, 0);
    @(posedge CLK) {DEBUG_HALT, EXT_DEBUG} <= 2'b01;
    apb(1, 8'h08, 32'h0000_0100, 0, 0);
    @(posedge CLK) {WPROT_EN, EXT_DEBUG, STANDBY} <= 3'b001;
    apb(0, 8'h30, 0, 0, 1);
    apb(0, 8'h00, 0, 32'h0000_0123, 0);
    @(posedge CLK) {STANDBY, PAD_IN} <= {1'b0, 32'h5A5A_F0F4};
    apb(1, 8'h2C, 32'hFFFF_FFFF, 0, 0);
    apb(0, 8'h20, 0, 32'h5A5A_F0F4, 0);
    apb(1, 8'h24, 32'h0000_000F, 0, 0);
    @(posedge CLK) PAD_IN <= 32'h0F0F_A5A5;
    repeat (3) @(posedge CLK);
    lbr(8'h20, 32'h0F0F_A5A5);
    apb(1, 8'h28, 32'h0000_0004, 0, 0);
    apb(1, 8'h34, 32'h0000_0001, 0, 0);
    repeat (2) @(negedge CLK);
    chk(PAD_OE_N & 32'h0000_0005, 32'h0000_0001);
    chk(PERIPH_IN, 32'h0000_0004);
    chk(PAD_INEN & 32'h0000_0005, 32'h0000_0004);
    @(posedge CLK) SHUTDOWN <= 1'b1;
    repeat (4) @(negedge CLK);
    chk(PAD_PULLEN, 32'h0000_0008);
    @(posedge CLK) SHUTDOWN <= 1'b0;
    apb(0, 8'h00, 0, 0, 0);
    apb(1, 8'h00, 32'h0000_0001, 0, 0);
    wrap_up;
  end
endmodule // gpc_port_test
bind gpc_port gpc_port_sva u_sva (.CLK, .SRST, .PSEL, .PENABLE, .PREADY, .APB_CLKEN, .LB_SEL, .EV_VALID,
  .EV_READY, .DEBUG_HALT, .SHUTDOWN, .PAD_OUT, .PAD_OE_N, .PAD_PULLEN, .PAD_PULLUP);
